// ==== include/tsr_pkg.sv ====
// shared constants and types for the thermal status and identity registers
`default_nettype none
package tsr_pkg;

  localparam int unsigned TSR_WORD_W  = 16;
  localparam int unsigned TSR_TEMP_W  = 12;
  localparam int unsigned TSR_HYST_W  = 12;
  localparam int unsigned TSR_CMP_W   = 14;

  // temperature word fields
  localparam int unsigned TSR_CRIT_BIT  = 15;
  localparam int unsigned TSR_ABOVE_BIT = 14;
  localparam int unsigned TSR_BELOW_BIT = 13;
  localparam int unsigned TSR_SIGN_BIT = 12;
  localparam int unsigned TSR_VAL_HI   = 11;
  localparam int unsigned TSR_VAL_LO   = 1;
  localparam int unsigned TSR_RSV_BIT  = 0;

  // threshold word fields, lsb 0.25 degC
  localparam int unsigned TSR_THR_HI = 12;
  localparam int unsigned TSR_THR_LO = 2;

  // bus feature control fields
  localparam int unsigned TSR_TMO_BIT = 7;
  localparam int unsigned TSR_ARA_BIT = 0;

  localparam logic [15:0] TSR_TEMP_RST = 16'h0000;
  localparam logic [15:0] TSR_CTRL_RST = 16'h0000;

  // identity defaults, arbitrary values
  localparam logic [15:0] TSR_MAKER_DEF = 16'h5a5a;
  localparam logic [7:0]  TSR_PART_DEF  = 8'h3c;
  localparam logic [7:0]  TSR_REV_DEF   = 8'h07;

  typedef enum logic [1:0] {
    TSR_SEL_TEMP  = 2'b00,
    TSR_SEL_MAKER = 2'b01,
    TSR_SEL_PART  = 2'b10,
    TSR_SEL_CTRL  = 2'b11
  } tsr_sel_type;

  typedef struct packed {
    logic                  valid;
    logic [TSR_TEMP_W-1:0] temp;
  } tsr_conv_type;

  typedef struct packed {
    logic [15:0]           crit;
    logic [15:0]           upper;
    logic [15:0]           lower;
    logic [TSR_HYST_W-1:0] hyst;
  } tsr_thr_type;

  typedef struct packed {
    logic        wr;
    tsr_sel_type sel;
    logic [15:0] wdata;
  } tsr_req_type;

endpackage : tsr_pkg
`default_nettype wire

// ==== hw/tsr_regs.sv ====
// thermal status, identity and bus feature control registers
`timescale 1ns/1ns
`default_nettype none
module tsr_regs
  import tsr_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = TSR_MAKER_DEF,
  parameter logic [7:0]  PART_ID  = TSR_PART_DEF,
  parameter logic [7:0]  REV_ID   = TSR_REV_DEF
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire tsr_conv_type conv,
  input  wire tsr_thr_type  thr,
  input  wire logic         crit_lock,
  input  wire logic         window_lock,
  input  wire tsr_req_type  req,
  output var  logic [15:0]  rdata,
  output var  logic [15:0]  temperature_reading,
  output var  logic         bus_timeout_disable,
  output var  logic         alert_address_disable
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trip comparison

  logic signed [TSR_CMP_W-1:0] t_new;
  logic signed [TSR_CMP_W-1:0] t_old;
  logic signed [TSR_CMP_W-1:0] t_crit;
  logic signed [TSR_CMP_W-1:0] t_upper;
  logic signed [TSR_CMP_W-1:0] t_lower;
  logic signed [TSR_CMP_W-1:0] t_hyst;
  logic                        rising;
  logic                        falling;
  logic [15:0]                 next_temperature_reading;
  logic                        above_critical_flag;
  logic                        above_window_flag;
  logic                        below_window_flag;

  always_comb begin
    t_new   = $signed({{2{conv.temp[TSR_TEMP_W-1]}}, conv.temp});
    t_old   = $signed({{2{temperature_reading[TSR_SIGN_BIT]}},
                       temperature_reading[TSR_SIGN_BIT:TSR_VAL_LO]});
    t_crit  = $signed({{2{thr.crit[TSR_THR_HI]}}, thr.crit[TSR_THR_HI:TSR_THR_LO], 1'b0});
    t_upper = $signed({{2{thr.upper[TSR_THR_HI]}}, thr.upper[TSR_THR_HI:TSR_THR_LO], 1'b0});
    t_lower = $signed({{2{thr.lower[TSR_THR_HI]}}, thr.lower[TSR_THR_HI:TSR_THR_LO], 1'b0});
    t_hyst  = $signed({2'b00, thr.hyst});
    rising  = t_new > t_old;
    falling = t_new < t_old;
    above_critical_flag = temperature_reading[TSR_CRIT_BIT];
    above_window_flag   = temperature_reading[TSR_ABOVE_BIT];
    below_window_flag   = temperature_reading[TSR_BELOW_BIT];
    // flags from the new reading against the old reading and thresholds, hysteresis on a fall, held if unchanged, no event pin term
    if (rising) begin
      above_critical_flag = t_new >= t_crit;
      above_window_flag   = t_new > t_upper;
      below_window_flag   = t_new < t_lower;
    end else if (falling) begin
      above_critical_flag = t_new >= (t_crit - t_hyst);
      above_window_flag   = t_new > (t_upper - t_hyst);
      below_window_flag   = t_new < (t_lower - t_hyst);
    end
    next_temperature_reading = temperature_reading;
    if (conv.valid) begin
      // whole word in one load
      next_temperature_reading = {above_critical_flag, above_window_flag, below_window_flag,
                                  conv.temp, 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temperature_reading <= TSR_TEMP_RST;
    end else begin
      temperature_reading <= next_temperature_reading;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus feature control

  logic ctrl_wr;
  logic next_bus_timeout_disable;
  logic next_alert_address_disable;

  always_comb begin
    ctrl_wr = req.wr && (req.sel == TSR_SEL_CTRL) && !(crit_lock || window_lock);
    next_bus_timeout_disable   = bus_timeout_disable;
    next_alert_address_disable = alert_address_disable;
    if (ctrl_wr) begin
      next_bus_timeout_disable   = req.wdata[TSR_TMO_BIT];
      next_alert_address_disable = req.wdata[TSR_ARA_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_timeout_disable   <= TSR_CTRL_RST[TSR_TMO_BIT];
      alert_address_disable <= TSR_CTRL_RST[TSR_ARA_BIT];
    end else begin
      bus_timeout_disable   <= next_bus_timeout_disable;
      alert_address_disable <= next_alert_address_disable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [15:0] next_rdata;

  always_comb begin
    unique case (req.sel)
      TSR_SEL_TEMP:  next_rdata = temperature_reading;
      TSR_SEL_MAKER: next_rdata = MAKER_ID;
      TSR_SEL_PART:  next_rdata = {PART_ID, REV_ID};
      TSR_SEL_CTRL: begin
        next_rdata = 16'h0000;
        next_rdata[TSR_TMO_BIT] = bus_timeout_disable;
        next_rdata[TSR_ARA_BIT] = alert_address_disable;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_temp_write_ignored: assert property (
    req.wr && !conv.valid |=> $stable(temperature_reading))
    else $error("temperature word changed on a host write");

  a_temp_value_load: assert property (
    conv.valid |=> temperature_reading[TSR_VAL_HI:TSR_VAL_LO] == $past(conv.temp[10:0]))
    else $error("temperature value not loaded");

  a_sign_bit_load: assert property (
    conv.valid |=> temperature_reading[TSR_SIGN_BIT] == $past(conv.temp[TSR_TEMP_W-1]))
    else $error("sign bit wrong");

  a_low_bit_zero: assert property (
    temperature_reading[TSR_RSV_BIT] == 1'b0)
    else $error("temperature bit 0 not zero");

  a_low_bit_read: assert property (
    req.sel == TSR_SEL_TEMP |=> rdata[TSR_RSV_BIT] == 1'b0)
    else $error("temperature bit 0 read back as one");

  a_crit_rise_set: assert property (
    conv.valid && rising && (t_new >= t_crit) |=> temperature_reading[TSR_CRIT_BIT])
    else $error("critical flag not set on rise");

  a_crit_rise_clear: assert property (
    conv.valid && rising && (t_new < t_crit) |=> !temperature_reading[TSR_CRIT_BIT])
    else $error("critical flag set below threshold");

  a_crit_fall_hold: assert property (
    conv.valid && falling && (t_new >= t_crit - t_hyst) && temperature_reading[TSR_CRIT_BIT]
    |=> temperature_reading[TSR_CRIT_BIT])
    else $error("critical flag dropped inside hysteresis");

  a_crit_fall_clear: assert property (
    conv.valid && falling && (t_new < t_crit - t_hyst) |=> !temperature_reading[TSR_CRIT_BIT])
    else $error("critical flag kept below hysteresis");

  a_window_rise_set: assert property (
    conv.valid && rising && (t_new > t_upper) |=> temperature_reading[TSR_ABOVE_BIT])
    else $error("above window flag not set on rise");

  a_window_rise_clear: assert property (
    conv.valid && rising && (t_new <= t_upper) |=> !temperature_reading[TSR_ABOVE_BIT])
    else $error("above window flag set inside window");

  a_window_fall_hold: assert property (
    conv.valid && falling && (t_new > t_upper - t_hyst) && temperature_reading[TSR_ABOVE_BIT]
    |=> temperature_reading[TSR_ABOVE_BIT])
    else $error("above window flag dropped inside hysteresis");

  a_window_fall_clear: assert property (
    conv.valid && falling && (t_new <= t_upper - t_hyst)
    |=> !temperature_reading[TSR_ABOVE_BIT])
    else $error("above window flag not cleared");

  a_below_rise_set: assert property (
    conv.valid && rising && (t_new < t_lower) |=> temperature_reading[TSR_BELOW_BIT])
    else $error("below window flag not set");

  a_below_rise_clear: assert property (
    conv.valid && rising && (t_new >= t_lower) |=> !temperature_reading[TSR_BELOW_BIT])
    else $error("below window flag set above lower limit");

  a_below_fall_set: assert property (
    conv.valid && falling && (t_new < t_lower - t_hyst)
    |=> temperature_reading[TSR_BELOW_BIT])
    else $error("below window flag not set on fall");

  a_below_fall_clear: assert property (
    conv.valid && falling && (t_new >= t_lower - t_hyst)
    |=> !temperature_reading[TSR_BELOW_BIT])
    else $error("below window flag set inside hysteresis");

  a_ident_fixed: assert property (
    req.sel == TSR_SEL_MAKER |=> rdata == MAKER_ID)
    else $error("maker identity changed");

  a_part_fixed: assert property (
    req.sel == TSR_SEL_PART |=> rdata == {PART_ID, REV_ID})
    else $error("part identity wrong");

  a_timeout_write: assert property (
    ctrl_wr |=> bus_timeout_disable == $past(req.wdata[TSR_TMO_BIT]))
    else $error("timeout disable not written");

  a_ara_write: assert property (
    ctrl_wr |=> alert_address_disable == $past(req.wdata[TSR_ARA_BIT]))
    else $error("alert address disable not written");

  a_lock_hold: assert property (
    req.wr && (crit_lock || window_lock)
    |=> $stable(bus_timeout_disable) && $stable(alert_address_disable))
    else $error("control changed while locked");

  a_ctrl_reserved: assert property (
    req.sel == TSR_SEL_CTRL |=> rdata[15:8] == 8'h00 && rdata[6:1] == 6'h00
                                && rdata[TSR_TMO_BIT] == $past(bus_timeout_disable)
                                && rdata[TSR_ARA_BIT] == $past(alert_address_disable))
    else $error("control reserved bits not zero");

  a_temp_atomic: assert property (
    !conv.valid |=> $stable(temperature_reading))
    else $error("temperature word changed without a conversion");

  a_sign_negative: assert property (
    conv.valid && (t_new < 0) |=> temperature_reading[TSR_SIGN_BIT])
    else $error("sign bit clear for a negative value");

  a_sign_positive: assert property (
    conv.valid && (t_new >= 0) |=> !temperature_reading[TSR_SIGN_BIT])
    else $error("sign bit set for a positive value");

  a_temp_read_back: assert property (
    req.sel == TSR_SEL_TEMP |=> rdata == $past(temperature_reading))
    else $error("temperature word read back wrong");

  a_flags_steady: assert property (
    conv.valid && !rising && !falling
    |=> temperature_reading[TSR_CRIT_BIT:TSR_BELOW_BIT]
        == $past(temperature_reading[TSR_CRIT_BIT:TSR_BELOW_BIT]))
    else $error("flags moved on an unchanged temperature");

  a_ctrl_other_sel: assert property (
    req.wr && (req.sel != TSR_SEL_CTRL)
    |=> $stable(bus_timeout_disable) && $stable(alert_address_disable))
    else $error("control changed by a write to another register");

  a_ctrl_idle_hold: assert property (
    !req.wr |=> $stable(bus_timeout_disable) && $stable(alert_address_disable))
    else $error("control changed without a write");

  a_ident_write: assert property (
    req.wr && (req.sel == TSR_SEL_PART) |=> rdata == {PART_ID, REV_ID})
    else $error("part identity changed by a write");

endmodule : tsr_regs
`default_nettype wire

// ==== dv/tsr_conv_src.sv ====
// conversion source model for the temperature port
`timescale 1ns/1ns
`default_nettype none
module tsr_conv_src
  import tsr_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         go,
  input  wire logic [11:0]  temp,
  output var  tsr_conv_type conv
);
  tsr_conv_type next_conv;
  always_comb begin
    next_conv.valid = go;
    next_conv.temp  = go ? temp : ~conv.temp;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      conv <= '0;
    end else begin
      conv <= next_conv;
    end
  end
endmodule : tsr_conv_src
`default_nettype wire

// ==== dv/test_thermal_status_id_registers.sv ====
// self-checking bench for the thermal status registers
`timescale 1ns/1ns
`default_nettype none
`define CHK(a,e) begin ev = (e); cmp_count++; if ((a) !== ev) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, ev); end end
module test_thermal_status_id_registers
  import tsr_pkg::*;
;
  logic               clk;
  logic               arst_n = 1'b0;
  logic               go = 1'b0;
  logic               crit_lock = 1'b0;
  logic               window_lock = 1'b0;
  logic               pt = 1'b0;
  logic               pr = 1'b0;
  logic               rd = 1'b0;
  logic               c7 = 1'b0;
  logic               c0 = 1'b0;
  logic [11:0]        t_in = '0;
  logic [2:0]         fl = '0;
  logic signed [13:0] prev = '0;
  logic [15:0]        ev, d, lt, rdata, temperature_reading;
  logic [15:0]        qt[$];
  logic [15:0]        qr[$];
  logic [15:0]        idv[4] = '{TSR_TEMP_RST, TSR_MAKER_DEF, {TSR_PART_DEF, TSR_REV_DEF}, 16'h0};
  logic [11:0]        sweep[11] = '{12'h0ce, 12'h0c0, 12'h0b0, 12'h090, 12'h030, 12'h010,
                                    12'h020, 12'h038, 12'hf30, 12'h0c8, 12'h0c8};
  logic               bus_timeout_disable, alert_address_disable;
  tsr_conv_type       conv;
  tsr_thr_type        thr = '{16'h0190, 16'h0140, 16'h0050, 12'h010};
  tsr_req_type        req = '0;
  int                 miscompares = 0;
  int                 cmp_count = 0;

  tsr_conv_src u_tsr_conv_src (.clk(clk), .arst_n(arst_n), .go(go), .temp(t_in), .conv(conv));
  tsr_regs u_tsr_regs (.clk(clk), .arst_n(arst_n), .conv(conv), .thr(thr),
    .crit_lock(crit_lock), .window_lock(window_lock), .req(req), .rdata(rdata),
    .temperature_reading(temperature_reading), .bus_timeout_disable(bus_timeout_disable),
    .alert_address_disable(alert_address_disable));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic signed [13:0] sc(input logic [15:0] w);
    return $signed({w[12], w[12], w[12:2], 1'b0});
  endfunction : sc
  task automatic put_temp(input logic [11:0] t);
    logic signed [13:0] v;
    logic signed [13:0] h;
    v = $signed({t[11], t[11], t});
    h = (v > prev) ? 14'sd0 : $signed({2'b00, thr.hyst});
    if (v != prev) fl = {v >= sc(thr.crit) - h, v > sc(thr.upper) - h, v < sc(thr.lower) - h};
    prev = v;
    lt = {fl, t, 1'b0};
    @(posedge clk);
    go <= 1'b1;
    t_in <= t;
    qt.push_back(lt);
    @(posedge clk);
    go <= 1'b0;
  endtask : put_temp
  task automatic rd_reg(input tsr_sel_type s, input logic [15:0] e);
    @(posedge clk);
    req.sel <= s;
    rd <= 1'b1;
    qr.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic wr_reg(input tsr_sel_type s, input logic [15:0] w);
    @(posedge clk);
    req <= '{1'b1, s, w};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr_reg
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    pt <= conv.valid;
    pr <= rd;
  end
  always @(negedge clk) begin
    if (pt) `CHK(temperature_reading, qt.pop_front())
    if (pr) `CHK(rdata, qr.pop_front())
  end
  initial begin
    #(5000 * 100);
    miscompares++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(73));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      rd_reg(tsr_sel_type'(i), idv[i]);
      wr_reg(tsr_sel_type'(i), (i == 3) ? 16'h0000 : 16'hffff);
      rd_reg(tsr_sel_type'(i), idv[i]);
    end
    $display("test reset and identity done");
    for (int i = 1; i <= 4; i++) begin
      @(posedge clk);
      {crit_lock, window_lock} <= 2'(i);
      d = 16'($urandom);
      d[7] = ~c7;
      d[0] = ~c0;
      if (i == 4) {c7, c0} = {d[7], d[0]};
      wr_reg(TSR_SEL_CTRL, d);
      @(negedge clk);
      `CHK(bus_timeout_disable, c7)
      `CHK(alert_address_disable, c0)
      rd_reg(TSR_SEL_CTRL, {8'h00, c7, 6'h00, c0});
    end
    wr_reg(TSR_SEL_CTRL, 16'hff7e);
    rd_reg(TSR_SEL_CTRL, 16'h0000);
    $display("test bus control done");
    foreach (sweep[k]) begin
      put_temp(sweep[k]);
      rd_reg(TSR_SEL_TEMP, lt);
    end
    repeat (40) put_temp(12'($urandom));
    repeat (3) @(posedge clk);
    $display("test temperature done");
    close_out();
  end
endmodule : test_thermal_status_id_registers
`default_nettype wire
